// ==== dsj_top.v ====
// stop, jog and pulse-follow sequencing with axi4-lite registers
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "dsj_consts.vh"
module dsj_top #(
    parameter AW = 8,
    parameter SPW = 16
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite slave
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // operator contacts and pulse pins, asynchronous
    input wire run_in,
    input wire run_hold_in,
    input wire jog_in,
    input wire direction_select,
    input wire digital_sel_in,
    input wire estop_n_in,
    input wire ref_pulse_in,
    input wire fb_pulse_in,
    // analog-side speed values
    input wire [SPW-1:0] analog_ref,
    input wire [SPW-1:0] motor_rpm,
    // drive outputs
    output reg drive_enable_r,
    output reg reverse_r,
    output reg [SPW-1:0] speed_ref_r,
    output reg ramp_bypass_r,
    output reg digital_mode_r,
    output reg [AW-1:0] current_cmd_r,
    output reg current_limit_r
);
//////////////////////////////////////////////////////////////////////
localparam ST_OFF = 4'b0001;
localparam ST_RUN = 4'b0010;
localparam ST_RAMP = 4'b0100;
localparam ST_JOG = 4'b1000;
//////////////////////////////////////////////////////////////////////
wire [7:0] pin_s;
dsj_sync #(.W(8)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({fb_pulse_in, ref_pulse_in, estop_n_in, digital_sel_in, direction_select, jog_in, run_hold_in, run_in}),
    .q(pin_s)
);
wire run_s = pin_s[0];
wire hold_s = pin_s[1];
wire jog_s = pin_s[2];
wire dir_s = pin_s[3];
wire dig_s = pin_s[4];
wire estop_n_s = pin_s[5];
reg ref_d_r;
reg fb_d_r;
always @(posedge aclk) begin
    if (!aresetn) begin
        ref_d_r <= 1'b0;
        fb_d_r <= 1'b0;
    end else begin
        ref_d_r <= pin_s[6];
        fb_d_r <= pin_s[7];
    end
end
wire ref_edge = pin_s[6] && !ref_d_r;
// encoder is conditioned upstream; one count per rising edge
wire fb_edge = pin_s[7] && !fb_d_r;
//////////////////////////////////////////////////////////////////////
reg [31:0] ctrl_r;
reg [SPW-1:0] jog_set_r;
reg [7:0] gain_r;
wire ramp_link = ctrl_r[`DSJ_CTRL_RAMP_LINK];
wire rate_link = ctrl_r[`DSJ_CTRL_RATE_LINK];
// gain 0 gives 90 counts, 255 gives 11
function [AW-1:0] gain_to_limit;
    input [7:0] g;
    reg [15:0] span;
    begin
        span = ({8'h00, `DSJ_GAIN_MIN_CNT} - {8'h00, `DSJ_GAIN_MAX_CNT}) * {8'h00, g};
        gain_to_limit = `DSJ_GAIN_MIN_CNT - span[15:8];
    end
endfunction
// jog reference is the jog setting scaled to 15 percent
function [SPW-1:0] jog_cap;
    input [SPW-1:0] v;
    reg [SPW+7:0] m;
    begin
        m = {8'h00, v} * {{SPW{1'b0}}, `DSJ_JOG_MAX_PCT};
        m = m / {{SPW{1'b0}}, `DSJ_JOG_PCT_DIV};
        jog_cap = m[SPW-1:0];
    end
endfunction
wire [AW-1:0] limit_cnt = gain_to_limit(gain_r);
//////////////////////////////////////////////////////////////////////
reg [3:0] st_r;
reg [3:0] st_nxt;
reg run_d_r;
wire run_edge = run_s && !run_d_r;
// closed hold contact seals run in; stop needs both open
wire stop_cmd = !run_s && !hold_s;
wire slow = motor_rpm < `DSJ_STOP_RPM;
wire dig_quiet;
always @* begin
    st_nxt = st_r;
    case (st_r)
        ST_OFF: begin
            if (run_edge)
                st_nxt = ST_RUN;
            else if (jog_s)
                st_nxt = ST_JOG;
        end
        ST_RUN: begin
            if (stop_cmd)
                st_nxt = ramp_link ? ST_RAMP : ST_OFF;
        end
        ST_RAMP: begin
            if (run_edge)
                st_nxt = ST_RUN;
            else if (digital_mode_r ? (dig_quiet && slow) : slow)
                st_nxt = ST_OFF;
        end
        ST_JOG: begin
            if (!jog_s)
                st_nxt = ST_OFF;
        end
        default: st_nxt = ST_OFF;
    endcase
    if (!estop_n_s)
        st_nxt = ST_OFF;
end
// accumulator and quiet-timer state
wire [AW-1:0] acc_count;
wire acc_lim;
wire acc_lost;
reg [15:0] quiet_cnt_r;
assign dig_quiet = quiet_cnt_r == 16'hffff;
always @(posedge aclk) begin
    if (!aresetn) begin
        st_r <= ST_OFF;
        run_d_r <= 1'b0;
        quiet_cnt_r <= 16'h0000;
    end else begin
        st_r <= st_nxt;
        run_d_r <= run_s;
        // digital stop waits for the source to go quiet
        if (ref_edge)
            quiet_cnt_r <= 16'h0000;
        else if (!dig_quiet)
            quiet_cnt_r <= quiet_cnt_r + 16'h0001;
    end
end
//////////////////////////////////////////////////////////////////////
wire active = st_nxt != ST_OFF;
dsj_accum #(.W(AW)) u_acc (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(!active),
    .ref_pulse(ref_edge && dig_s),
    .fb_pulse(fb_edge),
    .limit(limit_cnt),
    .count_r(acc_count),
    .at_limit_r(acc_lim),
    .lost_r(acc_lost)
);
reg [15:0] lost_cnt_r;
always @(posedge aclk) begin
    if (!aresetn) begin
        drive_enable_r <= 1'b0;
        reverse_r <= 1'b0;
        speed_ref_r <= {SPW{1'b0}};
        ramp_bypass_r <= 1'b0;
        digital_mode_r <= 1'b0;
        current_cmd_r <= {AW{1'b0}};
        current_limit_r <= 1'b0;
        lost_cnt_r <= 16'h0000;
    end else begin
        drive_enable_r <= active;
        digital_mode_r <= dig_s;
        reverse_r <= (st_nxt == ST_JOG) && dir_s;
        if (dig_s || st_nxt == ST_OFF || st_nxt == ST_RAMP)
            speed_ref_r <= {SPW{1'b0}};
        else if (st_nxt == ST_JOG)
            speed_ref_r <= jog_cap(jog_set_r);
        else
            speed_ref_r <= analog_ref;
        // jog is a step; digital ignores the rate link
        ramp_bypass_r <= dig_s || st_nxt == ST_JOG || !rate_link;
        current_cmd_r <= acc_count;
        current_limit_r <= acc_lim;
        if (acc_lost)
            lost_cnt_r <= lost_cnt_r + 16'h0001;
    end
end
//////////////////////////////////////////////////////////////////////
// write: take address and data in either order, answer after both
reg aw_got_r;
reg w_got_r;
reg [3:0] aw_r;
reg [31:0] wd_r;
reg [3:0] ws_r;
function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] s;
    integer i;
    begin
        merge = old;
        for (i = 0; i < 4; i = i + 1)
            if (s[i])
                merge[i*8 +: 8] = nw[i*8 +: 8];
    end
endfunction
reg [31:0] wm;
always @* begin
    wm = 32'h00000000;
    case (aw_r)
        `DSJ_ADDR_CTRL: wm = merge(ctrl_r, wd_r, ws_r);
        `DSJ_ADDR_JOG: wm = merge({{(32-SPW){1'b0}}, jog_set_r}, wd_r, ws_r);
        `DSJ_ADDR_GAIN: wm = merge({24'h000000, gain_r}, wd_r, ws_r);
        default: wm = 32'h00000000;
    endcase
end
wire do_wr = aw_got_r && w_got_r && !s_axi_bvalid;
wire wr_hit = aw_r == `DSJ_ADDR_CTRL || aw_r == `DSJ_ADDR_JOG || aw_r == `DSJ_ADDR_GAIN;
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        aw_r <= 4'h0;
        wd_r <= 32'h00000000;
        ws_r <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `DSJ_RESP_OKAY;
        ctrl_r <= `DSJ_CTRL_RESET;
        jog_set_r <= `DSJ_JOG_RESET;
        gain_r <= `DSJ_GAIN_RESET;
    end else begin
        s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
        s_axi_wready <= !w_got_r && !s_axi_wready && s_axi_wvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            aw_r <= {s_axi_awaddr[3:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wd_r <= s_axi_wdata;
            ws_r <= s_axi_wstrb;
        end
        if (do_wr) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `DSJ_RESP_OKAY : `DSJ_RESP_SLVERR;
            if (aw_r == `DSJ_ADDR_CTRL)
                ctrl_r <= {29'h00000000, wm[2:0]};
            if (aw_r == `DSJ_ADDR_JOG)
                jog_set_r <= wm[SPW-1:0];
            if (aw_r == `DSJ_ADDR_GAIN)
                gain_r <= wm[7:0];
        end else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end
end
// read: one cycle after address taken
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `DSJ_RESP_OKAY;
    end else begin
        s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `DSJ_RESP_OKAY;
            case ({s_axi_araddr[3:2], 2'b00})
                `DSJ_ADDR_CTRL: s_axi_rdata <= ctrl_r;
                `DSJ_ADDR_JOG: s_axi_rdata <= {{(32-SPW){1'b0}}, jog_set_r};
                `DSJ_ADDR_GAIN: s_axi_rdata <= {24'h000000, gain_r};
                `DSJ_ADDR_STAT: s_axi_rdata <= {lost_cnt_r, {(8-AW){1'b0}}, acc_count,
                    current_limit_r, digital_mode_r, drive_enable_r, 1'b0, st_r};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `DSJ_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
end
endmodule // dsj_top

// ==== dsj_consts.vh ====
// constants for the stop, jog and pulse-follow drive logic
// Function
// - linked stop keeps enable, zeroes reference
// - linked stop disables below ten rpm
// - unlinked stop disables at once, coast
// - digital linked stop needs pulse rate zero
// - jog non-latching, drives only while held
// - analog jog speed from jog setting
// - analog jog reference applied as step
// - run-hold open: run only while held
// - jog direction low forward, high reverse
// - digital select ignores analog settings
// - each reference pulse answered immediately, no ramp
// - four-pole feedback gives 120 pulses/rev
// - reference raises, feedback lowers accumulation
// - pulses lost only in current limit
// - gain sets limit count ninety to eleven
// - current command proportional to accumulator
// - overshoot decrements to zero, then waits
`ifndef DSJ_CONSTS_VH
`define DSJ_CONSTS_VH
`define DSJ_ADDR_CTRL 4'h0
`define DSJ_ADDR_JOG 4'h4
`define DSJ_ADDR_GAIN 4'h8
`define DSJ_ADDR_STAT 4'hc
`define DSJ_CTRL_RAMP_LINK 0
`define DSJ_CTRL_RATE_LINK 1
`define DSJ_CTRL_FOUR_POLE 2
`define DSJ_CTRL_RESET 32'h00000005
`define DSJ_JOG_RESET 16'h0000
`define DSJ_GAIN_RESET 8'h32
`define DSJ_GAIN_MIN_CNT 8'h5a
`define DSJ_GAIN_MAX_CNT 8'h0a
`define DSJ_STOP_RPM 16'h000a
`define DSJ_FB_PER_REV 8'h78
`define DSJ_JOG_MAX_PCT 8'h0f
`define DSJ_JOG_PCT_DIV 8'h64
`define DSJ_RESP_OKAY 2'b00
`define DSJ_RESP_SLVERR 2'b10
`endif

// ==== dsj_sync.v ====
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
module dsj_sync #(
    parameter W = 8
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // data
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
reg [W-1:0] meta_r;
always @(posedge aclk) begin
    if (!aresetn) begin
        meta_r <= {W{1'b0}};
        q <= {W{1'b0}};
    end else begin
        meta_r <= d;
        q <= meta_r;
    end
end
endmodule // dsj_sync

// ==== dsj_accum.v ====
// saturating up/down pulse accumulator
`timescale 1ns/10ps
module dsj_accum #(
    parameter W = 8
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // pulse events
    input wire clr,
    input wire ref_pulse,
    input wire fb_pulse,
    input wire [W-1:0] limit,
    // state
    output reg [W-1:0] count_r,
    output reg at_limit_r,
    output reg lost_r
);
reg [W-1:0] count_nxt;
always @* begin
    count_nxt = count_r;
    if (ref_pulse && !fb_pulse) begin
        if (count_r < limit)
            count_nxt = count_r + {{(W-1){1'b0}}, 1'b1};
    end else if (fb_pulse && !ref_pulse) begin
        if (count_r != {W{1'b0}})
            count_nxt = count_r - {{(W-1){1'b0}}, 1'b1};
    end
    if (count_nxt > limit)
        count_nxt = limit;
end
always @(posedge aclk) begin
    if (!aresetn || clr) begin
        count_r <= {W{1'b0}};
        at_limit_r <= 1'b0;
        lost_r <= 1'b0;
    end else begin
        count_r <= count_nxt;
        at_limit_r <= (count_nxt >= limit);
        // excess reference discarded only at limit
        lost_r <= ref_pulse && !fb_pulse && (count_r >= limit);
    end
end
endmodule // dsj_accum

// ==== dsj_top_monitor.sv ====
// port assertions for the stop, jog and pulse-follow block
`timescale 1ns/10ps
module dsj_top_monitor #(
    parameter AW = 8,
    parameter SPW = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // contacts and speed
    input wire logic run_in,
    input wire logic run_hold_in,
    input wire logic jog_in,
    input wire logic direction_select,
    input wire logic digital_sel_in,
    input wire logic estop_n_in,
    input wire logic [SPW-1:0] motor_rpm,
    // drive outputs
    input wire logic drive_enable_r,
    input wire logic reverse_r,
    input wire logic [SPW-1:0] speed_ref_r,
    input wire logic ramp_bypass_r,
    input wire logic digital_mode_r,
    input wire logic [AW-1:0] current_cmd_r
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////
    // eight-cycle windows cover sync flops plus state and output registers
    a_cmd_step: assert property (current_cmd_r != $past(current_cmd_r) |-> current_cmd_r == 0 ||
        current_cmd_r == $past(current_cmd_r) + 1'b1 || current_cmd_r == $past(current_cmd_r) - 1'b1)
        else $error("count moved by more than one");
    a_cmd_ceiling: assert property (current_cmd_r <= 8'h5a)
        else $error("count above ceiling");
    a_off_clear: assert property (!drive_enable_r [*3] |-> current_cmd_r == 0)
        else $error("count kept while off");
    a_estop_off: assert property (!estop_n_in [*8] |-> !drive_enable_r)
        else $error("enabled during emergency stop");
    a_jog_rev: assert property ((jog_in && !run_in && !run_hold_in && estop_n_in && direction_select) [*8]
        |-> reverse_r)
        else $error("jog not reverse");
    a_jog_fwd: assert property ((jog_in && !run_in && !run_hold_in && estop_n_in && !direction_select) [*8]
        |-> !reverse_r)
        else $error("jog not forward");
    a_jog_step: assert property ((jog_in && !run_in && !run_hold_in && !digital_sel_in && estop_n_in
        && motor_rpm < 16'h000a) [*8] |-> ramp_bypass_r && drive_enable_r)
        else $error("jog not applied as step");
    a_hold_release: assert property ((!jog_in && !run_in && !run_hold_in && !digital_sel_in
        && motor_rpm < 16'h000a) [*8] |-> !drive_enable_r)
        else $error("enabled with no command held");
    a_ramp_ref: assert property ((!run_in && !jog_in && !run_hold_in) [*8] ##0 drive_enable_r
        |-> speed_ref_r == 0)
        else $error("stop left reference nonzero");
    a_digital_sel: assert property (digital_sel_in [*8] |-> digital_mode_r && speed_ref_r == 0)
        else $error("digital select ignored");
endmodule // dsj_top_monitor

// ==== dsj_pulse_src.sv ====
// reference pulse source and encoder feedback model
`timescale 1ns/10ps
module dsj_pulse_src (
    // clock
    input wire logic aclk,
    // pulse pins, idle low
    output logic ref_pulse,
    output logic fb_pulse
);
    initial begin
        ref_pulse = 1'b0;
        fb_pulse = 1'b0;
    end
    // finite burst, three clocks high and low: slow enough to stay safe
    task burst(input int nref, input int nfb);
        for (int k = 0; k < nref || k < nfb; k++) begin
            @(posedge aclk);
            ref_pulse <= (k < nref);
            fb_pulse <= (k < nfb);
            repeat (3) @(posedge aclk);
            ref_pulse <= 1'b0;
            fb_pulse <= 1'b0;
            repeat (2) @(posedge aclk);
        end
    endtask
endmodule // dsj_pulse_src

// ==== dsj_top_bench.sv ====
// self-checking bench for the stop, jog and pulse-follow block
`timescale 1ns/10ps
`include "dsj_consts.vh"
module dsj_top_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic run_in = 1'b0, run_hold_in = 1'b0, jog_in = 1'b0, direction_select = 1'b0;
    logic digital_sel_in = 1'b0, estop_n_in = 1'b1;
    logic [15:0] analog_ref = 16'h0400, motor_rpm = 16'h0000;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ref_pulse_in, fb_pulse_in;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire drive_enable_r, reverse_r, ramp_bypass_r, digital_mode_r, current_limit_r;
    wire [15:0] speed_ref_r;
    wire [7:0] current_cmd_r;
    int miscompares = 0, samples_checked = 0;
    logic [31:0] rd;
    logic [1:0] rsp;
    dsj_top i_dsj_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .run_in, .run_hold_in, .jog_in, .direction_select, .digital_sel_in, .estop_n_in, .ref_pulse_in,
        .fb_pulse_in, .analog_ref, .motor_rpm, .drive_enable_r, .reverse_r, .speed_ref_r, .ramp_bypass_r,
        .digital_mode_r, .current_cmd_r, .current_limit_r);
    dsj_pulse_src i_dsj_pulse_src (.aclk, .ref_pulse(ref_pulse_in), .fb_pulse(fb_pulse_in));
    always #2 aclk = ~aclk;
    ////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // leading edge keeps a release and a new request out of one step
    task axi_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
    endtask
    task axi_rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask
    ////////////////////////////////////////////////////////////
    task t_regs;
        axi_rd(`DSJ_ADDR_CTRL);
        chk(rd, `DSJ_CTRL_RESET);
        axi_rd(`DSJ_ADDR_GAIN);
        chk(rd, `DSJ_GAIN_RESET);
        axi_wr(`DSJ_ADDR_JOG, 32'h000003e8);
        chk(rsp, `DSJ_RESP_OKAY);
        axi_rd(`DSJ_ADDR_JOG);
        chk(rd, 32'h000003e8);
        axi_wr(`DSJ_ADDR_STAT, 32'h00000001);
        chk(rsp, `DSJ_RESP_SLVERR);
        axi_rd(`DSJ_ADDR_STAT);
        chk(rsp, `DSJ_RESP_OKAY);
        chk(rd, 32'h00000001);
        $display("test regs done");
    endtask
    task t_jog;
        for (int d = 0; d < 2; d++) begin
            direction_select <= d[0];
            jog_in <= 1'b1;
            cyc(8);
            chk(drive_enable_r, 32'h1);
            chk(reverse_r, d);
            chk(ramp_bypass_r, 32'h1);
            chk(speed_ref_r, 32'h00000096);
            jog_in <= 1'b0;
            cyc(8);
            chk(drive_enable_r, 32'h0);
        end
        $display("test jog done");
    endtask
    task t_ramp;
        run_in <= 1'b1;
        motor_rpm <= 16'h01f4;
        cyc(8);
        chk(drive_enable_r, 32'h1);
        chk(speed_ref_r, 32'h00000400);
        run_in <= 1'b0;
        cyc(8);
        chk(drive_enable_r, 32'h1);
        chk(speed_ref_r, 32'h0);
        motor_rpm <= 16'h000a;
        cyc(8);
        chk(drive_enable_r, 32'h1);
        motor_rpm <= 16'h0009;
        cyc(8);
        chk(drive_enable_r, 32'h0);
        $display("test ramp done");
    endtask
    task t_coast;
        axi_wr(`DSJ_ADDR_CTRL, 32'h00000004);
        run_in <= 1'b1;
        motor_rpm <= 16'h01f4;
        cyc(8);
        run_in <= 1'b0;
        cyc(6);
        chk(drive_enable_r, 32'h0);
        motor_rpm <= 16'h0000;
        axi_wr(`DSJ_ADDR_CTRL, `DSJ_CTRL_RESET);
        $display("test coast done");
    endtask
    task t_digital;
        axi_wr(`DSJ_ADDR_GAIN, 32'h00000000);
        digital_sel_in <= 1'b1;
        run_hold_in <= 1'b1;
        run_in <= 1'b1;
        cyc(8);
        run_in <= 1'b0;
        cyc(8);
        chk(digital_mode_r, 32'h1);
        chk(drive_enable_r, 32'h1);
        chk(speed_ref_r, 32'h0);
        i_dsj_pulse_src.burst(5, 0);
        cyc(6);
        chk(current_cmd_r, 32'h5);
        i_dsj_pulse_src.burst(0, 8);
        cyc(6);
        chk(current_cmd_r, 32'h0);
        i_dsj_pulse_src.burst(95, 0);
        cyc(6);
        chk(current_cmd_r, 32'h5a);
        chk(current_limit_r, 32'h1);
        axi_rd(`DSJ_ADDR_STAT);
        chk(rd, 32'h00055ae2);
        estop_n_in <= 1'b0;
        cyc(8);
        chk(drive_enable_r, 32'h0);
        chk(current_cmd_r, 32'h0);
        estop_n_in <= 1'b1;
        run_hold_in <= 1'b0;
        jog_in <= 1'b1;
        cyc(8);
        i_dsj_pulse_src.burst(3, 0);
        cyc(6);
        chk(current_cmd_r, 32'h3);
        chk(speed_ref_r, 32'h0);
        jog_in <= 1'b0;
        cyc(8);
        chk(drive_enable_r, 32'h0);
        chk(current_cmd_r, 32'h0);
        digital_sel_in <= 1'b0;
        $display("test digital done");
    endtask
    task complete_run;
        $display("checked %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_jog;
        t_ramp;
        t_coast;
        t_digital;
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        complete_run;
    end
endmodule // dsj_top_bench
bind dsj_top dsj_top_monitor #(.AW(AW), .SPW(SPW)) i_dsj_top_monitor (.aclk, .aresetn, .run_in, .run_hold_in,
    .jog_in, .direction_select, .digital_sel_in, .estop_n_in, .motor_rpm, .drive_enable_r, .reverse_r,
    .speed_ref_r, .ramp_bypass_r, .digital_mode_r, .current_cmd_r);
